// ### mccr_params.svh
// constants for the core control register bank
`ifndef MCCR_PARAMS_SVH
`define MCCR_PARAMS_SVH
`define MCCR_A_SPL   8'h81
`define MCCR_A_DPL   8'h82
`define MCCR_A_DPH   8'h83
`define MCCR_A_PROGRAM_CONTROL  8'h87
`define MCCR_A_CFG   8'hAF
`define MCCR_A_SPH   8'hB7
`define MCCR_A_STB   8'hBF
`define MCCR_A_PSW   8'hD0
`define MCCR_A_ACC   8'hE0
`define MCCR_R_PROGRAM_CONTROL  8'h00
`define MCCR_R_SPH   8'h89
`define MCCR_R_STB   8'h00
`define MCCR_R_CFG   8'h81
`define MCCR_R_BYTE  8'h00
`define MCCR_R_PC    16'h0000
`define MCCR_R_XREN  1'b1
`define MCCR_B_BAUD  7
`define MCCR_B_BFLG  6
`define MCCR_B_RSV   7
`define MCCR_B_ESER  6
`define MCCR_B_SYNC  5
`define MCCR_B_MOD   4
`define MCCR_B_MODE  2
`define MCCR_B_SBE   1
`define MCCR_B_HFLG  0
`define MCCR_TOP     11'h7FF
`endif

// ### mccr_pkg.sv
// types for the core control register bank
package mccr_pkg;
  typedef enum logic [1:0] {
    MCCR_ADD,
    MCCR_AND,
    MCCR_OR,
    MCCR_XOR
  } mccr_op_e;
  typedef enum logic {
    MCCR_IDLE,
    MCCR_FETCH
  } mccr_fsm_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mccr_sfr_s;
  typedef struct packed {
    logic       start;
    mccr_op_e   kind;
    logic       use_bank;
    logic [2:0] idx;
    logic [7:0] lit;
  } mccr_op_s;
  typedef struct packed {
    logic           push;
    logic           pop;
    logic           fetch;
    logic [7:0]     opcode;
    logic           retire;
    logic [1:0]     len;
    logic           jump;
    logic [15:0]    target;
    logic           bank_wr;
    logic [2:0]     bank_idx;
    logic [7:0]     bank_wdata;
  } mccr_core_s;
  typedef struct packed {
    logic [7:0]       data_pointer_low;
    logic [7:0]       data_pointer_high;
    logic [7:0]       spl;
    logic [7:0]       stack_pointer_high;
    logic [7:0]       stb;
    logic [7:0]       program_control;
    logic [7:0]       cfg;
    logic [7:0]       program_status_word;
    logic [7:0]       acc;
    logic [15:0]      pc;
    logic [7:0]       ir;
    logic [31:0][7:0] bank;
    logic [7:0]       rdata;
    logic [7:0]       bank_rdata;
    logic             irq;
    logic             rst;
    logic             mark_prev;
    mccr_fsm_e        fsm;
    mccr_op_e         kind;
    logic [7:0]       arg;
    logic             done;
    logic             xram_en;
  } mccr_state_s;
endpackage

// ### mccr_core_regs.sv
// core control register bank with stack guard and bank ALU path
`timescale 1ns/100ps
`default_nettype none
`include "mccr_params.svh"
module mccr_core_regs (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // direct register access
  input  wire mccr_pkg::mccr_sfr_s  sfr,
  output var  logic [7:0]           sfr_rdata,
  // core events
  input  wire mccr_pkg::mccr_core_s core,
  input  wire mccr_pkg::mccr_op_s   op,
  output var  logic                 op_done,
  output var  logic [7:0]           bank_rdata,
  // core state
  output var  logic [15:0]          pc,
  output var  logic [7:0]           ir,
  output var  logic [7:0]           acc,
  output var  logic [15:0]          pointer_word,
  output var  logic [10:0]          stack_addr,
  // controls to peripherals
  output var  logic                 baud_doubler,
  output var  logic                 enhanced_serial_enable,
  output var  logic                 sync_port_select,
  output var  logic                 carrier_modulation_enable,
  output var  logic                 xram_move_enable,
  // stack guard responses
  output var  logic                 guard_irq,
  output var  logic                 guard_reset
);
  import mccr_pkg::*;

  // stack word is {stack high[2:0], stack low}; start is {stack high[5:3], 0x00}
  // guard checks run only while the protect enable bit is set
  // flags are set by hardware, cleared by writing zero (the hit flag only at or below the mark); a set wins

  logic        rst_m_q;
  logic        rst_n_q;
  mccr_state_s s_q;
  mccr_state_s s_d;

  // reset leaves through two flops so all state exits it on one edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  function automatic logic [4:0] bank_addr(input logic [7:0] program_status_word, input logic [2:0] idx);
    bank_addr = {program_status_word[4:3], idx};
  endfunction

  function automatic logic [10:0] stack_word(input logic [7:0] hi, input logic [7:0] lo);
    stack_word = {hi[2:0], lo};
  endfunction

  function automatic logic [10:0] start_word(input logic [2:0] bits);
    start_word = {bits, 8'h00};
  endfunction

  // level zero puts the mark at the top, where nothing can exceed it
  function automatic logic [10:0] mark_word(input logic [4:0] level);
    mark_word = `MCCR_TOP - {6'h00, level};
  endfunction

  function automatic logic wr_at(input mccr_sfr_s b, input logic [7:0] a);
    wr_at = b.wr && (b.addr == a);
  endfunction

  // read view of the register map; unmapped addresses read as zero
  function automatic logic [7:0] read_mux(input mccr_state_s st, input logic [7:0] a);
    unique case (a)
      `MCCR_A_SPL:  read_mux = st.spl;
      `MCCR_A_DPL:  read_mux = st.data_pointer_low;
      `MCCR_A_DPH:  read_mux = st.data_pointer_high;
      `MCCR_A_PROGRAM_CONTROL: read_mux = st.program_control;
      `MCCR_A_CFG:  read_mux = st.cfg;
      `MCCR_A_SPH:  read_mux = st.stack_pointer_high;
      `MCCR_A_STB:  read_mux = st.stb;
      `MCCR_A_PSW:  read_mux = st.program_status_word;
      `MCCR_A_ACC:  read_mux = st.acc;
      default:      read_mux = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] alu(input mccr_op_e k, input logic [7:0] a, input logic [7:0] b);
    unique case (k)
      MCCR_ADD: alu = a + b;
      MCCR_AND: alu = a & b;
      MCCR_OR:  alu = a | b;
      MCCR_XOR: alu = a ^ b;
    endcase
  endfunction

  logic [10:0] sp_cur;
  logic [10:0] sp_start;
  logic [10:0] mark;
  logic [10:0] sp_new;
  logic [10:0] sp_wr;
  logic        boundary_protect_enable;
  logic        mark_on;
  logic        move;
  logic        bottom_hit;
  logic        above;
  logic        hit_now;
  logic        viol;

  always_comb begin
    s_d        = s_q;
    s_d.rdata  = 8'h00;
    s_d.done   = 1'b0;
    s_d.irq    = 1'b0;
    s_d.rst    = 1'b0;
    sp_cur     = stack_word(s_q.stack_pointer_high, s_q.spl);
    sp_start   = start_word(s_q.stack_pointer_high[5:3]);
    boundary_protect_enable        = s_q.stb[`MCCR_B_SBE];
    mark       = mark_word(s_q.stb[7:3]);
    mark_on    = boundary_protect_enable && (s_q.stb[7:3] != 5'h00);
    sp_new     = sp_cur;
    move       = 1'b0;
    bottom_hit = 1'b0;
    sp_wr      = sp_cur;

    // push rolls over to start at top, pop may not go below start while the protect enable bit is set
    if (core.push) begin
      move   = 1'b1;
      sp_new = (sp_cur == `MCCR_TOP) ? sp_start : sp_cur + 11'h001;
    end else if (core.pop) begin
      // the pointer at start already holds the bottom entry
      if (boundary_protect_enable && sp_cur <= sp_start) begin
        bottom_hit = 1'b1;
      end else begin
        move   = 1'b1;
        sp_new = sp_cur - 11'h001;
      end
    end

    // register writes
    if (sfr.wr) begin
      if (wr_at(sfr, `MCCR_A_SPL)) begin
        sp_wr = {sp_cur[10:8], sfr.wdata};
      end
      if (wr_at(sfr, `MCCR_A_SPH)) begin
        sp_wr = {sfr.wdata[2:0], sp_cur[7:0]};
      end
      // a refused write keeps the pointer; the start bits still follow
      if (wr_at(sfr, `MCCR_A_SPL) || wr_at(sfr, `MCCR_A_SPH)) begin
        if (boundary_protect_enable && sp_wr < start_word(wr_at(sfr, `MCCR_A_SPH) ? sfr.wdata[5:3] : s_q.stack_pointer_high[5:3])) begin
          bottom_hit = 1'b1;
        end else begin
          move   = 1'b1;
          sp_new = sp_wr;
        end
      end
      unique case (sfr.addr)
        `MCCR_A_DPL:  s_d.data_pointer_low = sfr.wdata;
        `MCCR_A_DPH:  s_d.data_pointer_high = sfr.wdata;
        `MCCR_A_PROGRAM_CONTROL: s_d.program_control = sfr.wdata;
        `MCCR_A_CFG:  s_d.cfg = sfr.wdata;
        `MCCR_A_SPH: begin
          s_d.stack_pointer_high[7]   = sfr.wdata[7];
          s_d.stack_pointer_high[5:3] = sfr.wdata[5:3];
          if (!sfr.wdata[`MCCR_B_BFLG]) begin
            s_d.stack_pointer_high[`MCCR_B_BFLG] = 1'b0;
          end
        end
        `MCCR_A_STB: begin
          s_d.stb[7:1] = sfr.wdata[7:1];
          // clear honoured only at or below the mark
          if (!sfr.wdata[`MCCR_B_HFLG] && sp_cur <= mark) begin
            s_d.stb[`MCCR_B_HFLG] = 1'b0;
          end
        end
        `MCCR_A_PSW:  s_d.program_status_word = sfr.wdata;
        `MCCR_A_ACC:  s_d.acc = sfr.wdata;
        default: ;
      endcase
    end

    if (move) begin
      s_d.spl      = sp_new[7:0];
      s_d.stack_pointer_high[2:0] = sp_new[10:8];
    end

    // flags: hardware set wins over software clear
    above   = mark_on && (stack_word(s_d.stack_pointer_high, s_d.spl) > mark);
    // pulse on entry only; the flag itself stays set while above
    hit_now = above && !s_q.mark_prev;
    s_d.mark_prev = above;
    if (above) begin
      s_d.stb[`MCCR_B_HFLG] = 1'b1;
    end
    if (bottom_hit) begin
      s_d.stack_pointer_high[`MCCR_B_BFLG] = 1'b1;
    end
    viol = hit_now || bottom_hit;
    if (viol) begin
      s_d.irq = !s_q.stb[`MCCR_B_MODE];
      s_d.rst = s_q.stb[`MCCR_B_MODE];
    end

    // program counter and opcode
    // a jump wins over a retire in the same cycle
    if (core.jump) begin
      s_d.pc = core.target;
    end else if (core.retire) begin
      s_d.pc = s_q.pc + {14'h0000, core.len};
    end
    if (core.fetch) begin
      s_d.ir = core.opcode;
    end

    // working banks
    if (core.bank_wr) begin
      s_d.bank[bank_addr(s_q.program_status_word, core.bank_idx)] = core.bank_wdata;
    end
    // bank read is registered: index of the previous cycle
    s_d.bank_rdata = s_q.bank[bank_addr(s_q.program_status_word, core.bank_idx)];

    // accumulator operations
    unique case (s_q.fsm)
      MCCR_IDLE: begin
        if (op.start && op.use_bank) begin
          s_d.acc  = alu(op.kind, s_q.acc, s_q.bank[bank_addr(s_q.program_status_word, op.idx)]);
          s_d.done = 1'b1;
        end else if (op.start) begin
          // literal operand latched now, applied next cycle
          s_d.kind = op.kind;
          s_d.arg  = op.lit;
          s_d.fsm  = MCCR_FETCH;
        end
      end
      MCCR_FETCH: begin
        s_d.acc  = alu(s_q.kind, s_q.acc, s_q.arg);
        s_d.done = 1'b1;
        s_d.fsm  = MCCR_IDLE;
      end
    endcase
    // parity follows the accumulator value being registered
    s_d.program_status_word[0] = ^s_d.acc;
    s_d.xram_en = s_d.cfg[1] | s_d.cfg[0];

    // register reads
    if (sfr.rd) begin
      s_d.rdata = read_mux(s_q, sfr.addr);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // defaults loaded while the synchronised reset is low
      s_q      <= '0;
      s_q.program_control <= `MCCR_R_PROGRAM_CONTROL;
      s_q.stack_pointer_high  <= `MCCR_R_SPH;
      s_q.stb  <= `MCCR_R_STB;
      s_q.cfg  <= `MCCR_R_CFG;
      s_q.fsm  <= MCCR_IDLE;
      s_q.kind <= MCCR_ADD;
      s_q.data_pointer_low        <= `MCCR_R_BYTE;
      s_q.data_pointer_high        <= `MCCR_R_BYTE;
      s_q.spl        <= `MCCR_R_BYTE;
      s_q.program_status_word        <= `MCCR_R_BYTE;
      s_q.acc        <= `MCCR_R_BYTE;
      s_q.ir         <= `MCCR_R_BYTE;
      s_q.pc         <= `MCCR_R_PC;
      s_q.rdata      <= `MCCR_R_BYTE;
      s_q.bank_rdata <= `MCCR_R_BYTE;
      s_q.arg        <= `MCCR_R_BYTE;
      s_q.done       <= 1'b0;
      s_q.irq        <= 1'b0;
      s_q.rst        <= 1'b0;
      s_q.mark_prev  <= 1'b0;
      s_q.xram_en    <= `MCCR_R_XREN;
    end else begin
      s_q <= s_d;
    end
  end

  // every output comes straight from the state register
  assign sfr_rdata                 = s_q.rdata;
  assign op_done                   = s_q.done;
  assign bank_rdata                = s_q.bank_rdata;
  assign pc                        = s_q.pc;
  assign ir                        = s_q.ir;
  assign acc                       = s_q.acc;
  assign pointer_word              = {s_q.data_pointer_high, s_q.data_pointer_low};
  assign stack_addr                = {s_q.stack_pointer_high[2:0], s_q.spl};
  assign baud_doubler              = s_q.program_control[`MCCR_B_BAUD];
  assign enhanced_serial_enable    = s_q.cfg[`MCCR_B_ESER];
  assign sync_port_select          = s_q.cfg[`MCCR_B_SYNC];
  assign carrier_modulation_enable = s_q.cfg[`MCCR_B_MOD];
  assign xram_move_enable          = s_q.xram_en;
  assign guard_irq                 = s_q.irq;
  assign guard_reset               = s_q.rst;
endmodule // mccr_core_regs
`default_nettype wire

// ### mccr_core_regs_monitor.sv
// assertion checker for the core control register bank
`timescale 1ns/100ps
`default_nettype none
module mccr_core_regs_monitor (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 arst_n,
  // requests
  input wire mccr_pkg::mccr_sfr_s  sfr,
  input wire mccr_pkg::mccr_core_s core,
  input wire mccr_pkg::mccr_op_s   op,
  // observed state
  input wire logic                 op_done,
  input wire logic [15:0]          pc,
  input wire logic [7:0]           ir,
  input wire logic [15:0]          pointer_word,
  input wire logic [10:0]          stack_addr,
  input wire logic                 baud_doubler,
  input wire logic                 enhanced_serial_enable,
  input wire logic                 sync_port_select,
  input wire logic                 carrier_modulation_enable,
  input wire logic                 xram_move_enable,
  input wire logic                 guard_irq,
  input wire logic                 guard_reset
);
  import mccr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic lit;
  logic stk_wr;
  assign lit = op.start && !op.use_bank;
  assign stk_wr = sfr.wr && (sfr.addr == 8'h81 || sfr.addr == 8'hB7);
  sequence s_lit;
    !op_done ##1 op_done;
  endsequence
  property p_dpl;
    sfr.wr && sfr.addr == 8'h82 |=> pointer_word[7:0] == $past(sfr.wdata);
  endproperty
  property p_baud;
    sfr.wr && sfr.addr == 8'h87 |=> baud_doubler == $past(sfr.wdata[7]);
  endproperty
  property p_cfg;
    sfr.wr && sfr.addr == 8'hAF |=> {enhanced_serial_enable, sync_port_select, carrier_modulation_enable,
      xram_move_enable} == {$past(sfr.wdata[6:4]), |$past(sfr.wdata[1:0])};
  endproperty
  property p_pc;
    core.retire && !core.jump |=> pc == $past(pc) + 16'($past(core.len));
  endproperty
  property p_jmp;
    core.jump |=> pc == $past(core.target);
  endproperty
  property p_ir;
    core.fetch |=> ir == $past(core.opcode);
  endproperty
  property p_bank;
    op.start && op.use_bank && !$past(lit) |=> op_done;
  endproperty
  property p_lit;
    lit && !$past(lit) |=> s_lit;
  endproperty
  property p_push;
    core.push && !stk_wr && stack_addr != 11'h7FF |=> stack_addr == $past(stack_addr) + 11'h001;
  endproperty
  property p_excl;
    !(guard_irq && guard_reset);
  endproperty
  a_dpl: assert property (p_dpl) else $error("data pointer low not loaded");
  a_baud: assert property (p_baud) else $error("baud doubler wrong");
  a_cfg: assert property (p_cfg) else $error("configuration outputs wrong");
  a_pc: assert property (p_pc) else $error("program counter advance wrong");
  a_jmp: assert property (p_jmp) else $error("jump target not taken");
  a_ir: assert property (p_ir) else $error("opcode not held");
  a_bank: assert property (p_bank) else $error("bank operation not one cycle");
  a_lit: assert property (p_lit) else $error("literal operation not two cycles");
  a_push: assert property (p_push) else $error("push did not step stack");
  a_excl: assert property (p_excl) else $error("both guard responses at once");
endmodule // mccr_core_regs_monitor
`default_nettype wire

// ### tb_mccr_core_regs.sv
// self-checking bench for the core control register bank
`timescale 1ns/100ps
`default_nettype none
module tb_mccr_core_regs;
  import mccr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  mccr_sfr_s   sfr = '0;
  mccr_core_s  core = '0;
  mccr_op_s    op = '0;
  logic [7:0]  sfr_rdata, bank_rdata, ir, acc;
  logic [15:0] pc, pointer_word;
  logic [10:0] stack_addr;
  logic        op_done, bd, ese, sps, cme, xme, girq, grst;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [7:0]  ra[7] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'hAF, 8'hB7, 8'hBF};
  logic [7:0]  rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h89, 8'h00};
  logic [7:0]  cv[3] = '{8'hF0, 8'h82, 8'h80};
  mccr_core_regs mccr_core_regs_i (.sys_clk, .arst_n, .sfr, .sfr_rdata, .core, .op, .op_done, .bank_rdata,
    .pc, .ir, .acc, .pointer_word, .stack_addr, .baud_doubler(bd), .enhanced_serial_enable(ese),
    .sync_port_select(sps), .carrier_modulation_enable(cme), .xram_move_enable(xme),
    .guard_irq(girq), .guard_reset(grst));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic summarize();
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk) sfr = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk) sfr = '0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk) sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk) sfr = '0;
    chk(n, {8'h00, e}, {8'h00, sfr_rdata});
  endtask
  task automatic cy(input mccr_core_s c);
    @(negedge sys_clk) core = c;
    @(negedge sys_clk) core = '0;
  endtask
  task automatic go(input mccr_op_s o);
    @(negedge sys_clk) op = o;
    @(negedge sys_clk) op = '0;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int i = 0; i < 7; i++) rd("reset", ra[i], rv[i]);
    chk("reset out", 16'h0900, {4'h0, xme, stack_addr} | pc);
    wr(8'h82, 8'h5A);
    wr(8'h83, 8'hC3);
    chk("data_pointer_pair", 16'hC35A, pointer_word);
    rd("dph", 8'h83, 8'hC3);
    foreach (cv[i]) begin
      wr(8'hAF, cv[i]);
      chk("cfg", {11'h0, cv[i][6:4], 1'b0, |cv[i][1:0]}, {11'h0, ese, sps, cme, 1'b0, xme});
    end
    wr(8'h87, 8'h80);
    chk("baud", 16'h0001, {15'h0, bd});
    cy('{retire:1'b1, len:2'd3, default:'0});
    cy('{retire:1'b1, len:2'd1, default:'0});
    cy('{retire:1'b1, len:2'd2, default:'0});
    chk("pc", 16'h0006, pc);
    cy('{jump:1'b1, retire:1'b1, len:2'd1, target:16'h1234, default:'0});
    chk("pc", 16'h1234, pc);
    cy('{fetch:1'b1, opcode:8'hA5, default:'0});
    chk("ir", 16'h00A5, {8'h00, ir});
    wr(8'hD0, 8'h10);
    cy('{bank_wr:1'b1, bank_idx:3'd3, bank_wdata:8'h0F, default:'0});
    go('{start:1'b1, kind:MCCR_XOR, use_bank:1'b1, idx:3'd3, default:'0});
    chk("bank op", 16'h010F, {7'h0, op_done, acc});
    go('{start:1'b1, kind:MCCR_ADD, lit:8'h06, default:'0});
    chk("lit wait", 16'h0000, {15'h0, op_done});
    @(negedge sys_clk) chk("lit op", 16'h0115, {7'h0, op_done, acc});
    rd("psw", 8'hD0, 8'h11);
    wr(8'hD0, 8'h08);
    cy('{bank_idx:3'd3, default:'0});
    chk("bank1", 16'h0000, {8'h00, bank_rdata});
    wr(8'hBF, 8'h0A);
    wr(8'hB7, 8'h8F);
    wr(8'h81, 8'hFE);
    cy('{push:1'b1, default:'0});
    chk("mark", 16'h47FF, {1'b0, girq, grst, 2'h0, stack_addr});
    rd("flag", 8'hBF, 8'h0B);
    wr(8'hBF, 8'h0A);
    rd("flag kept", 8'hBF, 8'h0B);
    cy('{push:1'b1, default:'0});
    chk("roll", 16'h0100, {1'b0, girq, grst, 2'h0, stack_addr});
    wr(8'hBF, 8'h0A);
    rd("flag clr", 8'hBF, 8'h0A);
    cy('{pop:1'b1, default:'0});
    chk("bottom", 16'h4100, {1'b0, girq, grst, 2'h0, stack_addr});
    rd("bflag", 8'hB7, 8'hC9);
    wr(8'hBF, 8'h0E);
    cy('{pop:1'b1, default:'0});
    chk("reset mode", 16'h2100, {1'b0, girq, grst, 2'h0, stack_addr});
    wr(8'hBF, 8'h00);
    cy('{pop:1'b1, default:'0});
    chk("guard off", 16'h00FF, {1'b0, girq, grst, 2'h0, stack_addr});
    summarize();
  end
endmodule // tb_mccr_core_regs
bind mccr_core_regs mccr_core_regs_monitor mccr_core_regs_monitor_i (.sys_clk, .arst_n, .sfr, .core, .op,
  .op_done, .pc, .ir, .pointer_word, .stack_addr, .baud_doubler, .enhanced_serial_enable, .sync_port_select,
  .carrier_modulation_enable, .xram_move_enable, .guard_irq, .guard_reset);
`default_nettype wire
